// File: dv/scc_host_model.sv
// Host side of the byte port, standing in for the serial protocol engine
`timescale 1ns/1ns
module scc_host_model (
  // Clock
  input wire logic clk,
  // Byte port
  output logic ptr_stb,
  output logic [7:0] ptr,
  output logic wr_stb,
  output logic [7:0] wr_byte,
  output logic rd_stb,
  output logic stop,
  input wire logic done
);
  initial begin
    ptr_stb = 1'b0;
    ptr = 8'h00;
    wr_stb = 1'b0;
    wr_byte = 8'h00;
    rd_stb = 1'b0;
    stop = 1'b0;
  end

  // Kind 0 pointer, 1 write, 2 read, 3 stop; at least one idle edge, so a strobe never drops and rises at once
  task automatic xfer(input logic [1:0] kind, input logic [7:0] val, input int gap, output bit ok);
    int n;
    ok = 1'b1;
    repeat (gap + 1) @(negedge clk);
    ptr_stb = (kind == 2'd0);
    wr_stb = (kind == 2'd1);
    rd_stb = (kind == 2'd2);
    stop = (kind == 2'd3);
    ptr = val;
    wr_byte = val;
    @(negedge clk);
    {ptr_stb, wr_stb, rd_stb, stop} = 4'h0;
    // Released data lines show the inverse so a stale byte is never taken as fresh
    ptr = ~val;
    wr_byte = ~val;
    if (kind != 2'd3) begin
      ok = 1'b0;
      for (n = 0; n < 4 && !ok; n++) begin
        if (done === 1'b1) ok = 1'b1;
        else @(negedge clk);
      end
    end
  endtask
endmodule

// File: dv/spread_clock_config_regs_test.sv
// Self-checking bench for the spread clock configuration registers
`timescale 1ns/1ns
module spread_clock_config_regs_test;
  localparam int NVW = 20;
  localparam logic [4:0] FR = 5'h0b;
  logic clk, sys_rst, spread_pin, out_enable_pin, osc_off_pin_n;
  logic bus_ptr_stb, bus_wr_stb, bus_rd_stb, bus_stop, bus_done, bus_ack, clk_out_oe, clk_out_force_low;
  logic [7:0] bus_ptr, bus_wr_byte, bus_rd_byte;
  logic [2:0] bus_addr_sel;
  logic [4:0] dither_depth_half_pct, osc_range_offset;
  logic [3:0] dither_rate_log2, divider_exponent;
  logic [9:0] freq_step_code;
  logic [13:0] freq_step_khz;
  logic [9:0] exp_q[$];
  logic [9:0] e_cur;
  logic [15:0] w;
  int fail_count, tests_run, seed;
  logic [4:0] dep [8] = '{5'h01, 5'h02, 5'h04, 5'h00, 5'h08, 5'h00, 5'h00, 5'h10};
  logic [3:0] rt [4] = '{4'hd, 4'hc, 4'hb, 4'hc};

  scc_config_regs #(.NV_WR_CYCLES(NVW), .FACTORY_RANGE(FR)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .spread_pin(spread_pin), .out_enable_pin(out_enable_pin),
    .osc_off_pin_n(osc_off_pin_n), .bus_ptr_stb(bus_ptr_stb), .bus_ptr(bus_ptr), .bus_wr_stb(bus_wr_stb),
    .bus_wr_byte(bus_wr_byte), .bus_rd_stb(bus_rd_stb), .bus_stop(bus_stop), .bus_done(bus_done),
    .bus_ack(bus_ack), .bus_rd_byte(bus_rd_byte), .bus_addr_sel(bus_addr_sel),
    .dither_depth_half_pct(dither_depth_half_pct), .dither_rate_log2(dither_rate_log2),
    .divider_exponent(divider_exponent), .freq_step_code(freq_step_code), .freq_step_khz(freq_step_khz),
    .osc_range_offset(osc_range_offset), .clk_out_oe(clk_out_oe), .clk_out_force_low(clk_out_force_low)
  );

  scc_host_model u_host (
    .clk(clk), .ptr_stb(bus_ptr_stb), .ptr(bus_ptr), .wr_stb(bus_wr_stb), .wr_byte(bus_wr_byte),
    .rd_stb(bus_rd_stb), .stop(bus_stop), .done(bus_done)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic mis(input string m);
    fail_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp) mis($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  // Each answered request leaves {check data, ack, data} for the watcher
  task automatic op(input logic [1:0] k, input logic [7:0] v, input logic a, input logic c, input logic [7:0] r);
    bit ok;
    if (k != 2'd3) exp_q.push_back({c, a, r});
    u_host.xfer(k, v, $unsigned($random(seed)) % 3, ok);
    if (!ok) mis("no answer");
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] e);
    op(2'd0, adr, 1'b1, 1'b0, 8'h00);
    op(2'd2, 8'h00, 1'b1, 1'b1, e);
  endtask

  task automatic wr8(input logic [7:0] adr, input logic [7:0] b);
    op(2'd0, adr, 1'b1, 1'b0, 8'h00);
    op(2'd1, b, 1'b1, 1'b0, 8'h00);
  endtask

  // Words always go high byte then low byte from the base address
  task automatic wr16(input logic [7:0] adr, input logic [15:0] v);
    op(2'd0, adr, 1'b1, 1'b0, 8'h00);
    op(2'd1, v[15:8], 1'b1, 1'b0, 8'h00);
    op(2'd1, v[7:0], 1'b1, 1'b0, 8'h00);
  endtask

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  task automatic wait_nv();
    repeat (NVW + 5) @(negedge clk);
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (bus_done === 1'b1) begin
      tests_run++;
      if (exp_q.size() == 0) mis("unexpected answer");
      else begin
        e_cur = exp_q.pop_front();
        if (bus_ack !== e_cur[8] || (e_cur[9] && bus_rd_byte !== e_cur[7:0]))
          mis($sformatf("answer ack %b data %h exp %h", bus_ack, bus_rd_byte, e_cur));
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    mis("timeout");
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    spread_pin = 1'b0;
    out_enable_pin = 1'b1;
    osc_off_pin_n = 1'b1;
    fail_count = 0;
    tests_run = 0;
    seed = 32'h6574;
    do_reset();
    rd(8'h02, 8'h60);
    rd(8'h03, 8'h00);
    rd(8'h08, 8'h7d);
    rd(8'h09, 8'h00);
    rd(8'h0e, {3'h7, FR});
    rd(8'h0d, 8'hf0);
    rd(8'h37, {3'h0, FR});
    chk(dither_rate_log2, 4'hc, "rate");
    chk(freq_step_code, 10'h1f4, "step");
    chk(dither_depth_half_pct, 5'h00, "depth spread low");
    chk({clk_out_oe, clk_out_force_low}, 2'b10, "active out");
    spread_pin = 1'b1;
    settle();
    chk(dither_depth_half_pct, 5'h08, "depth spread high");
    $display("test defaults done");
    op(2'd0, 8'h37, 1'b1, 1'b0, 8'h00);
    op(2'd1, 8'($random(seed)), 1'b0, 1'b0, 8'h00);
    rd(8'h37, {3'h0, FR});
    rd(8'h20, 8'h00);
    $display("test read-only done");
    wr16(8'h08, 16'h4600);
    op(2'd0, 8'h37, 1'b0, 1'b0, 8'h00);
    chk(freq_step_code, 10'h118, "step code");
    chk(freq_step_khz, 14'd1400, "step khz");
    wait_nv();
    rd(8'h08, 8'h46);
    rd(8'h09, 8'h00);
    // Host derives the new window from the factory copy
    wr8(8'h0e, {3'h0, FR + 5'h1});
    op(2'd0, 8'h37, 1'b0, 1'b0, 8'h00);
    chk(osc_range_offset, FR + 5'h1, "offset");
    wait_nv();
    wr8(8'h0d, 8'h0d);
    op(2'd0, 8'h37, 1'b0, 1'b0, 8'h00);
    chk(bus_addr_sel, 3'h5, "addr sel");
    wait_nv();
    $display("test autosave done");
    out_enable_pin = 1'b0;
    settle();
    for (int i = 0; i < 16; i++) begin
      w = {i[1:0], i[2:0], i[0], i[3:0], 6'h00};
      wr16(8'h02, w);
      settle();
      chk(dither_depth_half_pct, dep[i[2:0]], "depth");
      chk(dither_rate_log2, rt[i[1:0]], "rate");
      chk(divider_exponent, (i > 8) ? 4'h8 : i[3:0], "divider");
      chk({clk_out_oe, clk_out_force_low}, {i[0], i[0]}, "idle drive");
    end
    out_enable_pin = 1'b1;
    $display("test fields done");
    op(2'd0, 8'h08, 1'b1, 1'b0, 8'h00);
    op(2'd1, 8'haa, 1'b1, 1'b0, 8'h00);
    op(2'd3, 8'h00, 1'b0, 1'b0, 8'h00);
    op(2'd1, 8'hbb, 1'b0, 1'b0, 8'h00);
    chk(freq_step_code, 10'h118, "step kept");
    wr8(8'h0e, {3'h0, FR + 5'h3});
    op(2'd0, 8'h37, 1'b1, 1'b0, 8'h00);
    do_reset();
    chk(osc_range_offset, FR + 5'h1, "offset recalled");
    chk(divider_exponent, 4'h0, "divider recalled");
    chk(dither_rate_log2, 4'hc, "rate recalled");
    chk(bus_addr_sel, 3'h5, "addr recalled");
    rd(8'h0d, 8'hfd);
    wr8(8'h0e, {3'h0, FR + 5'h2});
    op(2'd0, 8'h3f, 1'b1, 1'b0, 8'h00);
    op(2'd0, 8'h37, 1'b0, 1'b0, 8'h00);
    wait_nv();
    do_reset();
    chk(osc_range_offset, FR + 5'h2, "offset committed");
    $display("test power cycle done");
    give_verdict();
  end
endmodule

// File: hdl/scc_config_regs.sv
// Configuration registers, byte access port and nonvolatile control of the spread clock generator
`timescale 1ns/1ns
`include "scc_consts.svh"
// What this block does
// - Decode dither depth codes; others reserved.
// - Dither only while spread pin high.
// - Idle select 0 floats output when idle.
// - Idle select 1 holds output low.
// - Divide oscillator by two to exponent.
// - Exponent above eight acts as eight.
// - Each step code count adds 5kHz.
// - Step word moves as two bytes.
// - Step code sits left justified.
// - Range offset selects oscillator window.
// - Factory range copy is read only.
// - Autosave on: every write goes nonvolatile.
// - Autosave off: store only on commit, except the address register.
// - Reset reloads registers from nonvolatile image.
// - Address register always stored at once.
// - Address select gives slave address bits.
// - Commit copies all registers nonvolatile.
// - Divider/dither word moves as two bytes.
// - Dither rate selects 8192, 4096, 2048.
// - Refuse all transfers during nonvolatile write.
module scc_config_regs #(
  parameter int NV_WR_CYCLES = `SCC_NV_WR_CYCLES,
  parameter logic [4:0] FACTORY_RANGE = `SCC_DEF_RANGE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins
  input wire logic spread_pin,
  input wire logic out_enable_pin,
  input wire logic osc_off_pin_n,
  // Byte port from the serial protocol engine
  input wire logic bus_ptr_stb,
  input wire logic [7:0] bus_ptr,
  input wire logic bus_wr_stb,
  input wire logic [7:0] bus_wr_byte,
  input wire logic bus_rd_stb,
  input wire logic bus_stop,
  output logic bus_done,
  output logic bus_ack,
  output logic [7:0] bus_rd_byte,
  output logic [2:0] bus_addr_sel,
  // Oscillator control
  output logic [4:0] dither_depth_half_pct,
  output logic [3:0] dither_rate_log2,
  output logic [3:0] divider_exponent,
  output logic [9:0] freq_step_code,
  output logic [13:0] freq_step_khz,
  output logic [4:0] osc_range_offset,
  output logic clk_out_oe,
  output logic clk_out_force_low
);
  scc_nv_if nv ();

  scc_nv_store #(
    .NV_WR_CYCLES(NV_WR_CYCLES),
    .FACTORY_RANGE(FACTORY_RANGE)
  ) u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .nv(nv)
  );

  scc_pkg::scc_state_e state, next_state;
  scc_pkg::scc_word_t presc_word, next_presc_word;
  scc_pkg::scc_word_t step_word, next_step_word;
  logic [4:0] offset, next_offset;
  logic autosave_disable, next_autosave_disable;
  logic [2:0] addr_sel, next_addr_sel;
  logic [7:0] ptr, next_ptr;
  logic [7:0] pend_hi, next_pend_hi;
  logic pend_vld, next_pend_vld;
  logic next_done;
  logic next_ack;
  logic [7:0] rd_byte, next_rd_byte;
  logic nv_req, next_nv_req;
  logic [3:0] nv_mask, next_nv_mask;
  logic busy_eff;
  logic any_stb;

  // Two-stage synchronisers for the pins
  logic [2:0] pin_s1, pin_s2;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {osc_off_pin_n, out_enable_pin, spread_pin};
      pin_s2 <= pin_s1;
    end
  end
  logic spread_s, oe_s, run_s;
  assign spread_s = pin_s2[0];
  assign oe_s = pin_s2[1];
  assign run_s = pin_s2[2];

  // A request issued this cycle counts as busy before the store raises its flag
  assign busy_eff = nv.busy | nv_req;
  assign any_stb = bus_ptr_stb | bus_wr_stb | bus_rd_stb;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input scc_pkg::scc_word_t pw,
                                          input scc_pkg::scc_word_t sw, input logic [4:0] ofs,
                                          input logic wc, input logic [2:0] ad);
    case (a)
      `SCC_A_PRESC_HI: read_mux = pw[15:8];
      `SCC_A_PRESC_LO: read_mux = {pw[7:6], 6'h00};
      `SCC_A_STEP_HI: read_mux = sw[15:8];
      `SCC_A_STEP_LO: read_mux = {sw[7:6], 6'h00};
      `SCC_A_OFFSET: read_mux = {`SCC_OFFSET_FILL, ofs};
      `SCC_A_ADDR: read_mux = {`SCC_ADDR_FILL, wc, ad};
      `SCC_A_RANGE: read_mux = {3'h0, FACTORY_RANGE};
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    next_presc_word = presc_word;
    next_step_word = step_word;
    next_offset = offset;
    next_autosave_disable = autosave_disable;
    next_addr_sel = addr_sel;
    next_ptr = ptr;
    next_pend_hi = pend_hi;
    next_pend_vld = pend_vld;
    next_done = 1'b0;
    next_ack = 1'b0;
    next_rd_byte = rd_byte;
    next_nv_mask = 4'h0;
    case (state)
      scc_pkg::SCC_ST_RECALL: begin
        // Power cycle: live copies come back from the stored image
        next_presc_word = nv.image[`SCC_NV_PRESC] & 16'hffc0;
        next_step_word = nv.image[`SCC_NV_STEP] & 16'hffc0;
        next_offset = nv.image[`SCC_NV_OFFSET][4:0];
        next_autosave_disable = nv.image[`SCC_NV_ADDR][`SCC_F_WC];
        next_addr_sel = nv.image[`SCC_NV_ADDR][2:0];
        next_state = scc_pkg::SCC_ST_RUN;
      end
      scc_pkg::SCC_ST_RUN: begin
        if (bus_stop) begin
          next_pend_vld = 1'b0;
        end
        if (any_stb) begin
          next_done = 1'b1;
        end
        if (any_stb && busy_eff) begin
          next_ack = 1'b0;
        end else if (bus_ptr_stb) begin
          next_ptr = bus_ptr;
          next_pend_vld = 1'b0;
          next_ack = 1'b1;
          if (bus_ptr == `SCC_A_COMMIT) begin
            next_nv_mask = 4'hf;
          end
        end else if (bus_wr_stb) begin
          next_ptr = ptr + 8'h01;
          next_ack = 1'b1;
          next_pend_vld = 1'b0;
          case (ptr)
            `SCC_A_PRESC_HI, `SCC_A_STEP_HI: begin
              next_pend_hi = bus_wr_byte;
              next_pend_vld = 1'b1;
            end
            `SCC_A_PRESC_LO: begin
              if (pend_vld) begin
                next_presc_word = {pend_hi, bus_wr_byte[7:6], 6'h00};
                next_nv_mask[`SCC_NV_PRESC] = ~autosave_disable;
              end else begin
                next_ack = 1'b0;
              end
            end
            `SCC_A_STEP_LO: begin
              if (pend_vld) begin
                // Only the ten upper bits are kept
                next_step_word = {pend_hi, bus_wr_byte[7:6], 6'h00};
                next_nv_mask[`SCC_NV_STEP] = ~autosave_disable;
              end else begin
                next_ack = 1'b0;
              end
            end
            `SCC_A_OFFSET: begin
              next_offset = bus_wr_byte[4:0];
              next_nv_mask[`SCC_NV_OFFSET] = ~autosave_disable;
            end
            `SCC_A_ADDR: begin
              next_autosave_disable = bus_wr_byte[`SCC_F_WC];
              next_addr_sel = bus_wr_byte[2:0];
              next_nv_mask[`SCC_NV_ADDR] = 1'b1;
            end
            default: begin
              next_ack = 1'b0;
            end
          endcase
        end else if (bus_rd_stb) begin
          next_rd_byte = read_mux(ptr, presc_word, step_word, offset, autosave_disable, addr_sel);
          next_ptr = ptr + 8'h01;
          next_ack = 1'b1;
        end
      end
      default: begin
        next_state = scc_pkg::SCC_ST_RECALL;
      end
    endcase
    next_nv_req = |next_nv_mask;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= scc_pkg::SCC_ST_RECALL;
      presc_word <= `SCC_DEF_PRESC;
      step_word <= `SCC_DEF_STEP;
      offset <= `SCC_DEF_RANGE;
      autosave_disable <= 1'b0;
      addr_sel <= 3'h0;
      ptr <= 8'h00;
      pend_hi <= 8'h00;
      pend_vld <= 1'b0;
      rd_byte <= 8'h00;
      nv_req <= 1'b0;
      nv_mask <= 4'h0;
    end else begin
      state <= next_state;
      presc_word <= next_presc_word;
      step_word <= next_step_word;
      offset <= next_offset;
      autosave_disable <= next_autosave_disable;
      addr_sel <= next_addr_sel;
      ptr <= next_ptr;
      pend_hi <= next_pend_hi;
      pend_vld <= next_pend_vld;
      rd_byte <= next_rd_byte;
      nv_req <= next_nv_req;
      nv_mask <= next_nv_mask;
    end
  end

  assign nv.wr_req = nv_req;
  assign nv.wr_mask = nv_mask;
  assign nv.shadow[`SCC_NV_PRESC] = presc_word;
  assign nv.shadow[`SCC_NV_STEP] = step_word;
  assign nv.shadow[`SCC_NV_OFFSET] = {11'h000, offset};
  assign nv.shadow[`SCC_NV_ADDR] = {12'h000, autosave_disable, addr_sel};

  // Decoded oscillator controls, one cycle behind the accepted write
  logic [2:0] depth_code;
  logic [3:0] div_raw;
  logic idle_n;
  logic [4:0] next_depth;
  logic [3:0] next_rate;
  assign depth_code = presc_word[`SCC_F_DEPTH_HI:`SCC_F_DEPTH_LO];
  assign div_raw = presc_word[`SCC_F_DIV_HI:`SCC_F_DIV_LO];
  assign idle_n = run_s & oe_s;

  always_comb begin
    case (depth_code)
      3'h0: next_depth = 5'h01;
      3'h1: next_depth = 5'h02;
      3'h2: next_depth = 5'h04;
      3'h4: next_depth = 5'h08;
      3'h7: next_depth = 5'h10;
      default: next_depth = 5'h00;
    endcase
    if (!spread_s) begin
      next_depth = 5'h00;
    end
    // The unlisted rate code falls back to the default divisor
    case (presc_word[`SCC_F_RATE_HI:`SCC_F_RATE_LO])
      2'h0: next_rate = `SCC_RATE_8192;
      2'h2: next_rate = `SCC_RATE_2048;
      default: next_rate = `SCC_RATE_4096;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_done <= 1'b0;
      bus_ack <= 1'b0;
      bus_rd_byte <= 8'h00;
      bus_addr_sel <= 3'h0;
      dither_depth_half_pct <= 5'h00;
      dither_rate_log2 <= `SCC_RATE_4096;
      divider_exponent <= 4'h0;
      freq_step_code <= 10'h000;
      freq_step_khz <= 14'h0000;
      osc_range_offset <= 5'h00;
      clk_out_oe <= 1'b0;
      clk_out_force_low <= 1'b0;
    end else begin
      bus_done <= next_done;
      bus_ack <= next_ack;
      bus_rd_byte <= next_rd_byte;
      bus_addr_sel <= addr_sel;
      dither_depth_half_pct <= next_depth;
      dither_rate_log2 <= next_rate;
      divider_exponent <= (div_raw > `SCC_DIV_MAX) ? `SCC_DIV_MAX : div_raw;
      freq_step_code <= step_word[15:6];
      freq_step_khz <= 14'(step_word[15:6] * `SCC_STEP_KHZ);
      osc_range_offset <= offset;
      clk_out_oe <= idle_n | presc_word[`SCC_F_IDLE];
      clk_out_force_low <= ~idle_n & presc_word[`SCC_F_IDLE];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_DEPTH_8: assert property (spread_s && depth_code == 3'h7 |=> dither_depth_half_pct == 5'h10)
    else $error("depth code 7 not decoded as 8 percent");
  AST_NO_SPREAD: assert property (!spread_s |=> dither_depth_half_pct == 5'h00)
    else $error("dither applied with spread pin low");
  AST_HIZ: assert property (!idle_n && !presc_word[`SCC_F_IDLE] |=> !clk_out_oe && !clk_out_force_low)
    else $error("idle output not floating");
  AST_LOW: assert property (!idle_n && presc_word[`SCC_F_IDLE] |=> clk_out_oe && clk_out_force_low)
    else $error("idle output not held low");
  AST_DIV: assert property (div_raw <= 4'h8 |=> divider_exponent == $past(div_raw))
    else $error("divider exponent not passed");
  AST_DIV_CLAMP: assert property (div_raw > 4'h8 |=> divider_exponent == 4'h8)
    else $error("divider exponent not clamped");
  AST_NACK_BUSY: assert property (state == scc_pkg::SCC_ST_RUN && any_stb && busy_eff |=> bus_done && !bus_ack)
    else $error("transfer acknowledged during nonvolatile write");
  AST_ADDR_SAVE: assert property (state == scc_pkg::SCC_ST_RUN && bus_wr_stb && !busy_eff && ptr == `SCC_A_ADDR
                                  |=> nv_req && nv_mask[`SCC_NV_ADDR])
    else $error("address write not stored");
  AST_NO_AUTOSAVE: assert property (state == scc_pkg::SCC_ST_RUN && bus_wr_stb && !busy_eff && autosave_disable
                                    && ptr == `SCC_A_OFFSET |=> !nv_req)
    else $error("offset stored with autosave off");
  AST_STEP_LAG: assert property (step_word != $past(step_word) |=> freq_step_code == $past(step_word[15:6]))
    else $error("step code output stale");

  COV_COMMIT: cover property (bus_ptr_stb && bus_ptr == `SCC_A_COMMIT && !busy_eff ##1 nv_req);
  COV_STEP_WR: cover property (bus_wr_stb && ptr == `SCC_A_STEP_LO && pend_vld && !busy_eff);
  COV_BUSY_NACK: cover property (bus_done && !bus_ack && nv.busy);
  COV_RANGE_RD: cover property (bus_rd_stb && ptr == `SCC_A_RANGE && !busy_eff);
endmodule

// File: hdl/scc_nv_store.sv
// Nonvolatile image of the configuration words with write cycle timing
`timescale 1ns/1ns
`include "scc_consts.svh"
module scc_nv_store #(
  parameter int NV_WR_CYCLES = `SCC_NV_WR_CYCLES,
  parameter logic [4:0] FACTORY_RANGE = `SCC_DEF_RANGE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register side
  scc_nv_if.store nv
);
  // Contents survive sys_rst on purpose: reset models a power cycle
  // Power-on image is the factory state, in slot order, so no second process writes the array
  scc_pkg::scc_word_t mem [`SCC_NV_WORDS] = '{`SCC_DEF_PRESC, `SCC_DEF_STEP, {11'h000, FACTORY_RANGE}, `SCC_DEF_ADDR};
  logic [23:0] busy_cnt;
  logic [23:0] next_busy_cnt;
  logic busy;
  logic next_busy;

  always_comb begin
    next_busy = busy;
    next_busy_cnt = busy_cnt;
    if (busy) begin
      if (busy_cnt <= 24'h000001) begin
        next_busy = 1'b0;
        next_busy_cnt = 24'h000000;
      end else begin
        next_busy_cnt = busy_cnt - 24'h000001;
      end
    end else if (nv.wr_req) begin
      next_busy = 1'b1;
      next_busy_cnt = NV_WR_CYCLES[23:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      busy_cnt <= 24'h000000;
    end else begin
      busy <= next_busy;
      busy_cnt <= next_busy_cnt;
    end
  end

  // Requests are only issued while idle, so the snapshot is taken at once
  genvar gi;
  generate
    for (gi = 0; gi < `SCC_NV_WORDS; gi++) begin : g_word
      always_ff @(posedge clk) begin
        if (!sys_rst && !busy && nv.wr_req && nv.wr_mask[gi]) begin
          mem[gi] <= nv.shadow[gi];
        end
      end
      assign nv.image[gi] = mem[gi];
    end
  endgenerate

  assign nv.busy = busy;
endmodule

// File: shared/scc_consts.svh
// Register map, field positions, factory defaults and timing constants of the clock configuration block
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// Register byte addresses
`define SCC_A_PRESC_HI 8'h02
`define SCC_A_PRESC_LO 8'h03
`define SCC_A_STEP_HI 8'h08
`define SCC_A_STEP_LO 8'h09
`define SCC_A_ADDR 8'h0d
`define SCC_A_OFFSET 8'h0e
`define SCC_A_RANGE 8'h37
`define SCC_A_COMMIT 8'h3f

// Divider/dither word fields
`define SCC_F_RATE_HI 15
`define SCC_F_RATE_LO 14
`define SCC_F_DEPTH_HI 13
`define SCC_F_DEPTH_LO 11
`define SCC_F_IDLE 10
`define SCC_F_DIV_HI 9
`define SCC_F_DIV_LO 6
`define SCC_DIV_MAX 4'h8

// Address register fields
`define SCC_F_WC 3

// Fill bits of partly used bytes
`define SCC_OFFSET_FILL 3'h7
`define SCC_ADDR_FILL 4'hf

// Nonvolatile word slots
`define SCC_NV_WORDS 4
`define SCC_NV_PRESC 0
`define SCC_NV_STEP 1
`define SCC_NV_OFFSET 2
`define SCC_NV_ADDR 3

// Factory defaults
`define SCC_DEF_PRESC 16'h6000
`define SCC_DEF_STEP 16'h7d00
`define SCC_DEF_ADDR 16'h0000
`define SCC_DEF_RANGE 5'h12

// Dither rate as log2 of the oscillator divisor
`define SCC_RATE_8192 4'hd
`define SCC_RATE_4096 4'hc
`define SCC_RATE_2048 4'hb

// Step size in kHz
`define SCC_STEP_KHZ 4'h5

// Timing
`define SCC_CLK_MHZ 10
`define SCC_T_NV_WR_US 10000
`define SCC_NV_WR_CYCLES (`SCC_T_NV_WR_US * `SCC_CLK_MHZ)

`endif

// File: shared/scc_nv_if.sv
// Carrier between the register logic and its nonvolatile store
`timescale 1ns/1ns
interface scc_nv_if;
  logic wr_req;
  logic [3:0] wr_mask;
  scc_pkg::scc_word_t shadow [4];
  scc_pkg::scc_word_t image [4];
  logic busy;

  modport regs (output wr_req, output wr_mask, output shadow, input image, input busy);
  modport store (input wr_req, input wr_mask, input shadow, output image, output busy);
endinterface

// File: shared/scc_pkg.sv
// Types shared by the clock configuration block
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_ST_RECALL = 2'b01,
    SCC_ST_RUN = 2'b10
  } scc_state_e;

  typedef logic [15:0] scc_word_t;
endpackage
